/* src/cstr_regs.sv */
// calibration status, pin configuration and trigger select register bank
// Operation
// RULE1: three-bit offset averaging depth, resets to six
// RULE2: read-only status, code in bits four-two
// RULE3: halted flag set when background stops
// RULE4: halted flag cleared when calibration resumes
// RULE5: background off: halted set on foreground completion
// RULE6: foreground-complete flag in status bit zero
// RULE7: status pin selects fore, halted, alarm, low
// RULE8: select zero: software trigger bit, pin ignored
// RULE9: select one: hardware pin, software bit ignored
// RULE10: host idles with select zero, soft bit one
// RULE11: trigger low wakes sleeping core
// RULE12: hardware trigger synchronised before use
`timescale 1ns/100ps
`default_nettype none
module cstr_regs (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// register access port from the serial interface
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// events from the calibration sequencer
	input  wire logic       fg_finished_i,
	input  wire logic       bg_stopped_i,
	input  wire logic       cal_resumed_i,
	input  wire logic       bg_enabled_i,
	input  wire logic [2:0] cal_code_i,
	input  wire logic       alarm_i,
	// low-power wake control
	input  wire logic       lowpower_wake_by_trigger_i,
	input  wire logic       core_sleeping_i,
	output logic            core_wake_o,
	// pins
	input  wire logic       cal_trigger_pin_i,
	output logic            cal_status_pin_o,
	// to the calibration sequencer
	output logic      [2:0] offset_avg_depth_o,
	output logic            cal_trigger_o
);
	// register state
	logic       avg_rsvd;
	logic [2:0] offset_avg_depth;
	logic [2:0] cal_code;
	logic       fore_cal_complete;
	logic       bg_halted;
	logic [7:0] pin_cfg;
	logic [7:0] sw_trig_reg;
	logic       hw_trig_sync;

	// one place for the offset compare shared by the strobes and the checks
	function automatic logic cstr_hit(input logic [7:0] addr, input logic [7:0] offset);
		return addr == offset;
	endfunction

	// decode
	wire        wr_avg   = reg_wr_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_OFFSET_CAL_AVERAGING);
	wire        wr_pin   = reg_wr_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_CALIBRATION_PIN_CONFIG);
	wire        wr_swt   = reg_wr_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_SOFTWARE_CAL_TRIGGER);

	// fields
	wire        hw_trigger_select = pin_cfg[cstr_pkg::PIN_TRIG_SEL_BIT];
	wire  [1:0] status_pin_sel    = pin_cfg[cstr_pkg::PIN_STAT_SEL_LSB +: 2];
	wire        sw_trigger_bit    = sw_trig_reg[cstr_pkg::SWT_BIT];

	// read images
	wire  [7:0] avg_image  = {avg_rsvd, offset_avg_depth, cstr_pkg::AVG_LOW_READ};
	wire  [7:0] stat_image = {3'h0, cal_code, bg_halted, fore_cal_complete}; // RULE2

	// status flag next values; a set in the same cycle as a clear wins
	wire        fg_set        = fg_finished_i;
	wire        halt_set      = bg_stopped_i || (!bg_enabled_i && fg_finished_i); // RULE3 RULE5
	wire        next_fore     = fg_set || (fore_cal_complete && !cal_resumed_i); // RULE6
	wire        next_halted   = halt_set || (bg_halted && !cal_resumed_i); // RULE4

	// trigger source and pin routing
	wire        next_trigger  = hw_trigger_select ? hw_trig_sync : sw_trigger_bit; // RULE8 RULE9
	logic       next_pin;
	wire        next_wake     = lowpower_wake_by_trigger_i && core_sleeping_i && !cal_trigger_o; // RULE11
	logic [7:0] next_rdata;

	always_comb begin
		case (status_pin_sel) // RULE7
			cstr_pkg::PINSEL_FORE_CAL_COMPLETE: next_pin = fore_cal_complete;
			cstr_pkg::PINSEL_HALTED:  next_pin = bg_halted;
			cstr_pkg::PINSEL_ALARM:   next_pin = alarm_i;
			cstr_pkg::PINSEL_LOW:     next_pin = 1'b0;
			default:                  next_pin = 1'b0;
		endcase
	end

	// unmapped offsets read as zero
	always_comb begin
		case (reg_addr_i)
			cstr_pkg::ADDR_OFFSET_CAL_AVERAGING:   next_rdata = avg_image;
			cstr_pkg::ADDR_CALIBRATION_STATUS:     next_rdata = stat_image;
			cstr_pkg::ADDR_CALIBRATION_PIN_CONFIG: next_rdata = pin_cfg;
			cstr_pkg::ADDR_SOFTWARE_CAL_TRIGGER:   next_rdata = sw_trig_reg;
			default:                               next_rdata = 8'h00;
		endcase
	end

	// the pin goes through the synchroniser before anything else sees it
	cstr_trig_sync u_trig_sync ( // RULE12
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i (cal_trigger_pin_i),
		.sync_o  (hw_trig_sync)
	);

	// writable registers; the low averaging nibble is read-only and not stored
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			avg_rsvd         <= 1'b0;
			offset_avg_depth <= cstr_pkg::AVG_DEPTH_RESET; // RULE1
			pin_cfg          <= cstr_pkg::PIN_CFG_RESET;
			sw_trig_reg      <= cstr_pkg::SWT_RESET;
		end else begin
			if (wr_avg) begin
				avg_rsvd         <= reg_wdata_i[cstr_pkg::AVG_RSVD_BIT];
				offset_avg_depth <= reg_wdata_i[cstr_pkg::AVG_DEPTH_LSB +: cstr_pkg::AVG_DEPTH_W]; // RULE1
			end
			if (wr_pin) begin
				pin_cfg <= reg_wdata_i;
			end
			if (wr_swt) begin
				sw_trig_reg <= reg_wdata_i;
			end
		end
	end

	// status: documented as undefined after reset, cleared here for determinism
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cal_code          <= cstr_pkg::STAT_CODE_RESET;
			fore_cal_complete <= 1'b0;
			bg_halted         <= 1'b0;
		end else begin
			cal_code          <= cal_code_i; // RULE2
			fore_cal_complete <= next_fore; // RULE6
			bg_halted         <= next_halted; // RULE3 RULE4 RULE5
		end
	end

	// outputs; trigger resets high, matching the software bit's reset value
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cal_trigger_o    <= cstr_pkg::TRIG_IDLE;
			cal_status_pin_o <= 1'b0;
			core_wake_o      <= 1'b0;
			reg_rdata_o      <= 8'h00;
		end else begin
			cal_trigger_o    <= next_trigger; // RULE8 RULE9
			cal_status_pin_o <= next_pin; // RULE7
			core_wake_o      <= next_wake; // RULE11
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

	assign offset_avg_depth_o = offset_avg_depth;

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_avg_reset_six: assert property ( // RULE1
		$past(!rst_n_i) |-> offset_avg_depth_o == cstr_pkg::AVG_DEPTH_RESET
	) else $error("averaging depth not six after reset");

	a_avg_write_take: assert property ( // RULE1
		wr_avg |=> offset_avg_depth_o == $past(reg_wdata_i[6:4])
	) else $error("averaging depth write lost");

	a_status_code_read: assert property ( // RULE2
		reg_rd_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_CALIBRATION_STATUS)
		|=> reg_rdata_o[cstr_pkg::STAT_CODE_LSB +: cstr_pkg::STAT_CODE_W] == $past(cal_code)
	) else $error("status code read back wrong");

	a_status_code_bits: assert property ( // RULE2
		##1 reg_rd_i && reg_addr_i == cstr_pkg::ADDR_CALIBRATION_STATUS
		|=> reg_rdata_o[4:2] == $past(cal_code_i, 2) && reg_rdata_o[7:5] == 3'h0
	) else $error("status code not in bits four to two");

	a_halt_on_stop: assert property ( // RULE3
		bg_stopped_i |=> bg_halted
	) else $error("halted flag not set on stop");

	a_halt_clear_resume: assert property ( // RULE4
		cal_resumed_i && !bg_stopped_i && !(fg_finished_i && !bg_enabled_i) |=> !bg_halted
	) else $error("halted flag not cleared on resume");

	a_halt_fg_nobg: assert property ( // RULE5
		fg_finished_i && !bg_enabled_i |=> bg_halted && fore_cal_complete
	) else $error("halted flag not set after foreground with background off");

	a_fore_cal_complete_flag: assert property ( // RULE6
		fg_finished_i |=> fore_cal_complete
	) else $error("foreground flag not set");

	a_pin_held_low: assert property ( // RULE7
		status_pin_sel == cstr_pkg::PINSEL_LOW |=> !cal_status_pin_o
	) else $error("status pin not low");

	a_pin_mirror_halt: assert property ( // RULE7
		status_pin_sel == cstr_pkg::PINSEL_HALTED |=> cal_status_pin_o == $past(bg_halted)
	) else $error("status pin not mirroring halted flag");

	a_trig_soft_path: assert property ( // RULE8
		!hw_trigger_select |=> cal_trigger_o == $past(sw_trigger_bit)
	) else $error("software trigger not selected");

	a_trig_hw_settle: assert property ( // RULE9 RULE12
		(hw_trigger_select && !wr_pin && $stable(cal_trigger_pin_i))[*6]
		|-> cal_trigger_o == cal_trigger_pin_i
	) else $error("hardware trigger not followed after settling");

	a_wake_on_low: assert property ( // RULE11
		lowpower_wake_by_trigger_i && core_sleeping_i && !cal_trigger_o |=> core_wake_o
	) else $error("core not woken by low trigger");

	a_no_wake_high: assert property ( // RULE11
		cal_trigger_o |=> !core_wake_o
	) else $error("core woken while trigger high");

	a_fg_read_bit: assert property ( // RULE6
		reg_rd_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_CALIBRATION_STATUS) |=> reg_rdata_o[cstr_pkg::STAT_FG_BIT] == $past(fore_cal_complete)
	) else $error("foreground flag not in bit zero");

	a_halt_read_bit: assert property ( // RULE3
		reg_rd_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_CALIBRATION_STATUS) |=> reg_rdata_o[cstr_pkg::STAT_HALT_BIT] == $past(bg_halted)
	) else $error("halted flag not in bit one");

	a_fg_clear_resume: assert property ( // RULE6
		cal_resumed_i && !fg_finished_i |=> !fore_cal_complete
	) else $error("foreground flag not cleared on resume");

	a_halt_stays: assert property ( // RULE3
		bg_halted && !cal_resumed_i |=> bg_halted
	) else $error("halted flag dropped without resume");

	a_pin_mirror_fg: assert property ( // RULE7
		status_pin_sel == cstr_pkg::PINSEL_FORE_CAL_COMPLETE |=> cal_status_pin_o == $past(fore_cal_complete)
	) else $error("status pin not mirroring foreground flag");

	a_pin_mirror_alarm: assert property ( // RULE7
		status_pin_sel == cstr_pkg::PINSEL_ALARM |=> cal_status_pin_o == $past(alarm_i)
	) else $error("status pin not mirroring alarm");

	a_status_read_only: assert property ( // RULE2
		reg_wr_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_CALIBRATION_STATUS)
		|=> $stable(pin_cfg) && $stable(sw_trig_reg) && $stable(offset_avg_depth) && $stable(avg_rsvd)
	) else $error("status write changed a register");

	a_avg_low_nibble: assert property ( // RULE1
		reg_rd_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_OFFSET_CAL_AVERAGING) |=> reg_rdata_o[3:0] == cstr_pkg::AVG_LOW_READ
	) else $error("averaging low nibble not one");

	a_unmapped_zero: assert property (
		reg_rd_i && !cstr_hit(reg_addr_i, cstr_pkg::ADDR_OFFSET_CAL_AVERAGING)
			&& !cstr_hit(reg_addr_i, cstr_pkg::ADDR_CALIBRATION_STATUS)
			&& !cstr_hit(reg_addr_i, cstr_pkg::ADDR_CALIBRATION_PIN_CONFIG)
			&& !cstr_hit(reg_addr_i, cstr_pkg::ADDR_SOFTWARE_CAL_TRIGGER) |=> reg_rdata_o == 8'h00
	) else $error("unmapped offset read not zero");

	a_rdata_hold: assert property (
		!reg_rd_i |=> $stable(reg_rdata_o)
	) else $error("read data changed without a read");

	a_pin_cfg_write: assert property ( // RULE7
		wr_pin |=> pin_cfg == $past(reg_wdata_i)
	) else $error("pin configuration write lost");

	a_swt_write: assert property ( // RULE8
		wr_swt |=> sw_trig_reg == $past(reg_wdata_i)
	) else $error("software trigger write lost");

	a_trig_pin_ignored: assert property ( // RULE8
		!hw_trigger_select && !wr_swt && !wr_pin |=> ##1 $stable(cal_trigger_o)
	) else $error("trigger moved while software source steady");

	a_trig_soft_ignored: assert property ( // RULE9
		hw_trigger_select |=> cal_trigger_o == $past(hw_trig_sync)
	) else $error("trigger not taken from synchronised pin");

	a_wake_needs_mode: assert property ( // RULE11
		!lowpower_wake_by_trigger_i |=> !core_wake_o
	) else $error("core woken outside trigger mode");

	a_wake_off_awake: assert property ( // RULE11
		!core_sleeping_i |=> !core_wake_o
	) else $error("wake requested for an awake core");

	a_reset_outputs: assert property ( // RULE8
		$past(!rst_n_i)
		|-> cal_trigger_o && !cal_status_pin_o && !core_wake_o && reg_rdata_o == 8'h00
	) else $error("outputs not at reset values");

	c_hw_trigger_low: cover property (hw_trigger_select && !cal_trigger_o);
	c_halt_then_resume: cover property (bg_halted ##1 cal_resumed_i ##1 !bg_halted);
	c_pin_alarm: cover property (status_pin_sel == cstr_pkg::PINSEL_ALARM && cal_status_pin_o);
	c_core_wake: cover property (core_wake_o);
	c_status_read: cover property (reg_rd_i && cstr_hit(reg_addr_i, cstr_pkg::ADDR_CALIBRATION_STATUS));
endmodule
`default_nettype wire

/* src/cstr_pkg.sv */
// constants for the calibration status and trigger register bank
package cstr_pkg;
	// register offsets
	localparam logic [7:0] ADDR_OFFSET_CAL_AVERAGING   = 8'h68;
	localparam logic [7:0] ADDR_CALIBRATION_STATUS     = 8'h6a;
	localparam logic [7:0] ADDR_CALIBRATION_PIN_CONFIG = 8'h6b;
	localparam logic [7:0] ADDR_SOFTWARE_CAL_TRIGGER   = 8'h6c;

	// offset_cal_averaging fields
	localparam int         AVG_DEPTH_LSB   = 4;
	localparam int         AVG_DEPTH_W     = 3;
	localparam int         AVG_RSVD_BIT    = 7;
	localparam logic [2:0] AVG_DEPTH_RESET = 3'h6;
	localparam logic [3:0] AVG_LOW_READ    = 4'h1;

	// calibration_status fields
	localparam int         STAT_FG_BIT     = 0;
	localparam int         STAT_HALT_BIT   = 1;
	localparam int         STAT_CODE_LSB   = 2;
	localparam int         STAT_CODE_W     = 3;
	localparam logic [2:0] STAT_CODE_RESET = 3'h0;

	// calibration_pin_config fields
	localparam int         PIN_TRIG_SEL_BIT = 0;
	localparam int         PIN_STAT_SEL_LSB = 1;
	localparam int         PIN_RSVD_LSB     = 3;
	localparam logic [7:0] PIN_CFG_RESET    = 8'h00;

	// software_cal_trigger fields
	localparam int         SWT_BIT   = 0;
	localparam logic [7:0] SWT_RESET = 8'h01;

	// status pin source selections
	localparam logic [1:0] PINSEL_FORE_CAL_COMPLETE = 2'h0;
	localparam logic [1:0] PINSEL_HALTED  = 2'h1;
	localparam logic [1:0] PINSEL_ALARM   = 2'h2;
	localparam logic [1:0] PINSEL_LOW     = 2'h3;

	// idle level of the synchronised hardware trigger
	localparam logic TRIG_IDLE = 1'b1;
endpackage

/* src/cstr_trig_sync.sv */
// three-stage synchroniser with agreement filter for the hardware trigger pin
`timescale 1ns/100ps
`default_nettype none
module cstr_trig_sync (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// asynchronous pin and its synchronised level
	input  wire logic async_i,
	output logic      sync_o
);
	logic stage1;
	logic stage2;
	logic stage3;
	wire  agree = (stage2 == stage3);

	// stage1 feeds only stage2; the agreement check looks at stages two and three
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stage1 <= cstr_pkg::TRIG_IDLE;
			stage2 <= cstr_pkg::TRIG_IDLE;
			stage3 <= cstr_pkg::TRIG_IDLE;
			sync_o <= cstr_pkg::TRIG_IDLE;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
			if (agree) begin
				sync_o <= stage3;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/cstr_host.sv */
// host-side model: register strobes and hardware trigger pin
`timescale 1ns/100ps
`default_nettype none
module cstr_host (
	// clock
	input  wire logic       clk_i,
	// register port toward the device
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i,
	// trigger pin
	output logic            trig_pin_o
);
	initial begin
		addr_o     = 8'h00;
		wr_o       = 1'b0;
		wdata_o    = 8'h00;
		rd_o       = 1'b0;
		trig_pin_o = 1'b1;
	end
	// released address and data lines show the inverse so a stale value is never mistaken for a live one
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
		@(negedge clk_i);
		addr_o  = a;
		wdata_o = d;
		wr_o    = w;
		rd_o    = ~w;
		@(negedge clk_i);
		wr_o    = 1'b0;
		rd_o    = 1'b0;
		addr_o  = ~a;
		wdata_o = ~d;
		q       = rdata_i;
	endtask
	task automatic pin(input logic v);
		@(negedge clk_i);
		trig_pin_o = v;
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the calibration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cstr_row_t;
	logic       clk_i   = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [7:0] addr, wdata, rdata, q;
	logic       wr, rd, pin, wake, stat_pin, trig;
	logic [2:0] ev    = 3'h0;
	logic [2:0] code  = 3'h5;
	logic       bge   = 1'b0;
	logic       alarm = 1'b1;
	logic       lpw   = 1'b0;
	logic       slp   = 1'b0;
	logic [2:0] depth;
	int         err_total = 0;
	int         n_tests   = 0;
	cstr_row_t  rows [6]  = '{'{8'h6a, 8'hff, 8'h14}, '{8'h55, 8'haa, 8'h00}, '{8'h6b, 8'hf8, 8'hf8},
		'{8'h6c, 8'hfe, 8'hfe}, '{8'h68, 8'h3f, 8'h31}, '{8'h68, 8'hff, 8'hf1}};
	cstr_host host (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata),
		.trig_pin_o(pin));
	cstr_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .fg_finished_i(ev[0]), .bg_stopped_i(ev[1]),
		.cal_resumed_i(ev[2]), .bg_enabled_i(bge), .cal_code_i(code), .alarm_i(alarm),
		.lowpower_wake_by_trigger_i(lpw), .core_sleeping_i(slp), .core_wake_o(wake),
		.cal_trigger_pin_i(pin), .cal_status_pin_o(stat_pin), .offset_avg_depth_o(depth),
		.cal_trigger_o(trig));
	initial forever #4 clk_i = ~clk_i;
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		host.xfer(a, d, 1'b1, q);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.xfer(a, 8'h00, 1'b0, q);
		chk("rdata", q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// event pulses last exactly one cycle
	task automatic fire(input logic [2:0] v);
		@(negedge clk_i);
		ev = v;
		@(negedge clk_i);
		ev = 3'h0;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		err_total++;
		wrap_up();
	end
	initial begin
		logic [3:0] pexp;
		pexp = 4'b0110;
		tick(6);
		rst_n_i = 1'b1;
		chk("depth", {5'h0, depth}, 8'h06);
		chk("trig", {7'h0, trig}, 8'h01);
		rchk(8'h68, 8'h61);
		rchk(8'h6b, 8'h00);
		rchk(8'h6c, 8'h01);
		foreach (rows[i]) begin
			w(rows[i].a, rows[i].d);
			rchk(rows[i].a, rows[i].e);
		end
		chk("depth", {5'h0, depth}, 8'h07);
		chk("rdata_hold", rdata, 8'hf1);
		tick(3);
		chk("trig", {7'h0, trig}, 8'h00);
		w(8'h6c, 8'h01);
		host.pin(1'b0);
		tick(8);
		chk("trig", {7'h0, trig}, 8'h01);
		w(8'h6b, 8'h01);
		tick(3);
		chk("trig", {7'h0, trig}, 8'h00);
		lpw = 1'b1;
		slp = 1'b1;
		tick(2);
		chk("wake", {7'h0, wake}, 8'h01);
		host.pin(1'b1);
		tick(3);
		chk("trig", {7'h0, trig}, 8'h00);
		tick(5);
		chk("trig", {7'h0, trig}, 8'h01);
		chk("wake", {7'h0, wake}, 8'h00);
		w(8'h6c, 8'h00);
		tick(3);
		chk("trig", {7'h0, trig}, 8'h01);
		// a one-cycle dip never reaches agreement in stages two and three
		host.pin(1'b0);
		host.pin(1'b1);
		tick(8);
		chk("trig", {7'h0, trig}, 8'h01);
		chk("wake", {7'h0, wake}, 8'h00);
		rchk(8'h6a, 8'h14);
		fire(3'h1);
		rchk(8'h6a, 8'h17);
		fire(3'h4);
		rchk(8'h6a, 8'h14);
		bge = 1'b1;
		fire(3'h1);
		rchk(8'h6a, 8'h15);
		fire(3'h2);
		rchk(8'h6a, 8'h17);
		fire(3'h4);
		fire(3'h2);
		for (int s = 0; s < 4; s++) begin
			w(8'h6b, 8'(s << 1));
			tick(2);
			chk("stat_pin", {7'h0, stat_pin}, {7'h0, pexp[s]});
		end
		w(8'h6b, 8'h04);
		alarm = 1'b0;
		tick(3);
		chk("stat_pin", {7'h0, stat_pin}, 8'h00);
		// set and clear in one cycle: the set wins
		fire(3'h5);
		rchk(8'h6a, 8'h15);
		fire(3'h6);
		rchk(8'h6a, 8'h16);
		rst_n_i = 1'b0;
		tick(2);
		rst_n_i = 1'b1;
		chk("depth", {5'h0, depth}, 8'h06);
		chk("trig", {7'h0, trig}, 8'h01);
		chk("stat_pin", {7'h0, stat_pin}, 8'h00);
		chk("wake", {7'h0, wake}, 8'h00);
		chk("rdata", rdata, 8'h00);
		tick(1);
		chk("trig", {7'h0, trig}, 8'h01);
		chk("stat_pin", {7'h0, stat_pin}, 8'h00);
		rchk(8'h68, 8'h61);
		rchk(8'h6b, 8'h00);
		rchk(8'h6c, 8'h01);
		rchk(8'h6a, 8'h14);
		wrap_up();
	end
endmodule
`default_nettype wire
